// ==== wide_neg_pkg.sv ====
// Purpose: shared constants for data path width negotiation
// Assumes: message-level link, one byte per req/ack pulse
// Notes: imported by both ends and by the message decoder
// ==========================================================
// Overview of operation
// - width message is 01h, 02h, 03h, exponent
// - renegotiate after resets and power cycle
// - wide device never rejects width message
// - negotiated width only in data phases
// - width before synchronous negotiation
// - accepted width message reverts synchronous mode
// - width bytes are two to exponent
// - one width for all logical units
// - offer largest, responder echoes or lowers
// - use responder width; zero or reject: 8-bit
// - initiator asserts atn, target replies
// - abnormal missing response: fall to 8-bit
// - reject or parity error negates agreement
// - parity error retransmit success restores agreement
// - target stops parity retries, initiator aborts
// - initiator asserts atn before last ack
// - no agreement until target leaves message out
// - target retry exhaustion: bus free, catastrophic
// - target reject after initiator reply negates
// - agreement persists until reset or renegotiation
// - avoid renegotiating on every selection
package wide_neg_pkg;
  localparam logic [7:0] MSG_EXT  = 8'h01;
  localparam logic [7:0] MSG_LEN  = 8'h02;
  localparam logic [7:0] MSG_WIDE = 8'h03;
  localparam logic [7:0] MSG_REJ  = 8'h07;
  localparam logic [7:0] MSG_PERR = 8'h09;
  localparam logic [7:0] MSG_BDR  = 8'h0c;
  localparam logic [1:0] EXP_8    = 2'h0;
  localparam logic [1:0] EXP_16   = 2'h1;
  localparam logic [1:0] EXP_32   = 2'h2;
  localparam logic [1:0] IDX_EXT  = 2'h0;
  localparam logic [1:0] IDX_LEN  = 2'h1;
  localparam logic [1:0] IDX_CODE = 2'h2;
  localparam logic [1:0] IDX_EXP  = 2'h3;
  localparam int ID_W      = 4;
  localparam int NPEER     = 2 ** ID_W;
  localparam int CLK_NS    = 4;
  localparam int TMO_NS    = 2000;
  localparam int TMO_CYC   = (TMO_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMO_W     = 12;
  localparam int RETRY_MAX = 3;
  localparam int RT_W      = 4;

  typedef enum logic [2:0] {PH_FREE, PH_MSG_OUT, PH_MSG_IN, PH_DATA} phase_t;
  typedef enum logic [1:0] {MK_WDTR, MK_REJ, MK_PERR} msg_kind_t;

  function automatic logic [7:0] msg_byte(msg_kind_t k, logic [1:0] idx, logic [1:0] e);
    logic [7:0] b;
    b = MSG_REJ;
    if (k == MK_PERR) b = MSG_PERR;
    else if (k == MK_WDTR) begin
      case (idx)
        IDX_EXT:  b = MSG_EXT;
        IDX_LEN:  b = MSG_LEN;
        IDX_CODE: b = MSG_WIDE;
        default:  b = {6'h00, e};
      endcase
    end
    return b;
  endfunction : msg_byte

  function automatic logic msg_last(msg_kind_t k, logic [1:0] idx);
    return (k != MK_WDTR) || (idx == IDX_EXP);
  endfunction : msg_last

  // reserved exponents above 02h clamp down to our own limit
  function automatic logic [1:0] resp_exp(logic [7:0] off, logic [1:0] mine);
    return (off > {6'h00, mine}) ? mine : off[1:0];
  endfunction : resp_exp
endpackage : wide_neg_pkg

// ==== wide_link_if.sv ====
// Purpose: message-level link between target and initiator
// Assumes: both ends on one clock; ack is a one-cycle pulse
// Notes: no clocking block, testbench joins the ends
`timescale 1ns/1ns
interface wide_link_if;
  wide_neg_pkg::phase_t          phase;
  logic                          req;
  logic [7:0]                    tgt_db;
  logic                          ack;
  logic                          atn;
  logic                          sel;
  logic [7:0]                    ini_db;
  logic [wide_neg_pkg::ID_W-1:0] ini_id;

  modport target (output phase, req, tgt_db, input ack, atn, sel, ini_db, ini_id);
  modport initiator (input phase, req, tgt_db, output ack, atn, sel, ini_db, ini_id);
endinterface : wide_link_if

// ==== msg_decode.sv ====
// Purpose: classify incoming message bytes
// Assumes: take is high for exactly one cycle per byte
// Notes: strobes are combinational on the taken byte
`timescale 1ns/1ns
module msg_decode (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic       take,
  input  wire logic [7:0] byte_in,
  output logic            wdtr_ok,
  output logic            rej,
  output logic            perr,
  output logic            bdr,
  output logic            junk,
  output logic            mid
);
  import wide_neg_pkg::*;
  logic [1:0] idx_q;
  logic [1:0] idx_d;

  always_comb begin
    idx_d   = idx_q;
    wdtr_ok = 1'b0;
    rej     = 1'b0;
    perr    = 1'b0;
    bdr     = 1'b0;
    junk    = 1'b0;
    if (clr) idx_d = IDX_EXT;
    else if (take) begin
      case (idx_q)
        IDX_EXT: begin
          rej  = (byte_in == MSG_REJ);
          perr = (byte_in == MSG_PERR);
          bdr  = (byte_in == MSG_BDR);
          if (byte_in == MSG_EXT) idx_d = IDX_LEN;
          else junk = !(rej || perr || bdr);
        end
        IDX_LEN: begin
          idx_d = (byte_in == MSG_LEN) ? IDX_CODE : IDX_EXT;
          junk  = (byte_in != MSG_LEN);
        end
        IDX_CODE: begin
          idx_d = (byte_in == MSG_WIDE) ? IDX_EXP : IDX_EXT;
          junk  = (byte_in != MSG_WIDE);
        end
        default: begin
          wdtr_ok = 1'b1;
          idx_d   = IDX_EXT;
        end
      endcase
    end
  end

  assign mid = (idx_q != IDX_EXT);

  always_ff @(posedge clk) begin
    if (srst) idx_q <= IDX_EXT;
    else idx_q <= idx_d;
  end
endmodule : msg_decode

// ==== wide_initiator.sv ====
// Purpose: initiator end of width negotiation
// Assumes: target drops req in the cycle after each ack
// Notes: width_q holds agreement with the one attached target
`timescale 1ns/1ns
module wide_initiator #(
  parameter logic [1:0] MAX_EXP = wide_neg_pkg::EXP_32
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  wide_link_if.initiator                     lk,
  input  wire logic                          connect,
  input  wire logic [wide_neg_pkg::ID_W-1:0] my_id,
  input  wire logic                          reneg,
  input  wire logic                          inject_perr,
  output logic [1:0]                         width_q,
  output logic                               srev_q,
  output logic                               fail_q
);
  import wide_neg_pkg::*;
  typedef enum logic {I_OFF, I_ON} istate_t;

  istate_t         st_q, st_d;
  phase_t          pho_q;
  msg_kind_t       kind_q, kind_d;
  logic [1:0]      idx_q, idx_d, val_q, val_d, off_q, off_d, pend_q, pend_d, width_d;
  logic [7:0]      db_q, db_d;
  logic [ID_W-1:0] id_q, id_d;
  logic sel_q, sel_d, atn_q, atn_d, ack_q, ack_d, neg_q, neg_d, mine_q, mine_d;
  logic wait_q, wait_d, pdone_q, pdone_d, seen_q, seen_d, srev_d, fail_d;
  logic in_tk, out_tk, d_wdtr, d_rej, d_perr, d_bdr, d_junk, d_mid;

  assign in_tk  = lk.req && !ack_q && (lk.phase == PH_MSG_IN);
  assign out_tk = lk.req && !ack_q && (lk.phase == PH_MSG_OUT);

  msg_decode u_dec (
    .clk     (clk),
    .srst    (srst),
    .clr     (lk.phase != PH_MSG_IN),
    .take    (in_tk),
    .byte_in (lk.tgt_db),
    .wdtr_ok (d_wdtr),
    .rej     (d_rej),
    .perr    (d_perr),
    .bdr     (d_bdr),
    .junk    (d_junk),
    .mid     (d_mid)
  );

  task automatic send(input msg_kind_t k, input logic [1:0] v);
    atn_d  = 1'b1;
    kind_d = k;
    val_d  = v;
    idx_d  = IDX_EXT;
  endtask : send

  always_comb begin
    st_d = st_q; sel_d = sel_q; id_d = id_q; atn_d = atn_q; kind_d = kind_q;
    idx_d = idx_q; val_d = val_q; off_d = off_q; pend_d = pend_q; width_d = width_q;
    neg_d = neg_q || reneg; mine_d = mine_q; wait_d = wait_q; pdone_d = pdone_q;
    seen_d = seen_q; srev_d = 1'b0; fail_d = 1'b0; db_d = db_q;
    ack_d = in_tk || out_tk;
    if (out_tk) begin
      db_d = msg_byte(kind_q, idx_q, val_q);
      if (msg_last(kind_q, idx_q)) begin
        atn_d = 1'b0;
        idx_d = IDX_EXT;
      end else idx_d = idx_q + 2'h1;
    end
    case (st_q)
      I_OFF: if (connect) begin
        st_d   = I_ON;
        sel_d  = 1'b1;
        id_d   = my_id;
        seen_d = 1'b0;
        if (neg_q) begin
          send(MK_WDTR, MAX_EXP);
          off_d   = MAX_EXP;
          mine_d  = 1'b1;
          pdone_d = 1'b0;
        end
      end
      I_ON: begin
        if (lk.phase != PH_FREE) seen_d = 1'b1;
        if (wait_q && pho_q == PH_MSG_OUT && lk.phase != PH_MSG_OUT) begin
          wait_d  = 1'b0;
          width_d = (lk.phase == PH_FREE) ? EXP_8 : pend_q;
          srev_d  = (lk.phase != PH_FREE);
        end
        if (mine_q && (lk.phase == PH_DATA || (seen_q && lk.phase == PH_FREE))) begin
          mine_d  = 1'b0;
          width_d = EXP_8;
          fail_d  = 1'b1;
        end
        // let go of the target when it frees the bus, or once data is reached and the user drops connect
        if ((seen_q && lk.phase == PH_FREE) || (!connect && lk.phase == PH_DATA)) begin
          st_d  = I_OFF;
          sel_d = 1'b0;
          atn_d = 1'b0;
        end
        if (d_wdtr && mine_q) begin
          if (lk.tgt_db > {6'h00, off_q}) begin
            send(MK_REJ, EXP_8);
            mine_d  = 1'b0;
            width_d = EXP_8;
            fail_d  = 1'b1;
          end else if (inject_perr && !pdone_q) begin
            send(MK_PERR, EXP_8);
            pdone_d = 1'b1;
            width_d = EXP_8;
          end else begin
            width_d = lk.tgt_db[1:0];
            srev_d  = 1'b1;
            mine_d  = 1'b0;
            neg_d   = 1'b0;
          end
        end else if (d_wdtr) begin
          neg_d   = 1'b0;
          width_d = EXP_8;
          if (MAX_EXP == EXP_8) send(MK_REJ, EXP_8); // narrow only
          else begin
            send(MK_WDTR, resp_exp(lk.tgt_db, MAX_EXP));
            pend_d = resp_exp(lk.tgt_db, MAX_EXP);
            wait_d = 1'b1;
          end
        end else if (d_rej) begin
          width_d = EXP_8;
          mine_d  = 1'b0;
          wait_d  = 1'b0;
          neg_d   = 1'b0;
        end
      end
      default: st_d = I_OFF;
    endcase
  end

  assign lk.sel    = sel_q;
  assign lk.atn    = atn_q;
  assign lk.ack    = ack_q;
  assign lk.ini_db = db_q;
  assign lk.ini_id = id_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= I_OFF; sel_q <= 1'b0; id_q <= '0; atn_q <= 1'b0; ack_q <= 1'b0;
      kind_q <= MK_WDTR; idx_q <= IDX_EXT; val_q <= EXP_8; off_q <= EXP_8;
      pend_q <= EXP_8; width_q <= EXP_8; neg_q <= 1'b1; mine_q <= 1'b0;
      wait_q <= 1'b0; pdone_q <= 1'b0; seen_q <= 1'b0; srev_q <= 1'b0;
      fail_q <= 1'b0; db_q <= 8'h00; pho_q <= PH_FREE;
    end else begin
      st_q <= st_d; sel_q <= sel_d; id_q <= id_d; atn_q <= atn_d; ack_q <= ack_d;
      kind_q <= kind_d; idx_q <= idx_d; val_q <= val_d; off_q <= off_d;
      pend_q <= pend_d; width_q <= width_d; neg_q <= neg_d; mine_q <= mine_d;
      wait_q <= wait_d; pdone_q <= pdone_d; seen_q <= seen_d; srev_q <= srev_d;
      fail_q <= fail_d; db_q <= db_d; pho_q <= lk.phase;
    end
  end
endmodule : wide_initiator

// ==== wide_target.sv ====
// Purpose: target end of width negotiation with per-peer widths
// Assumes: initiator acks each req once, atn rises with last ack
// Notes: widths survive reselection; only resets and new
//        negotiation change them
`timescale 1ns/1ns
module wide_target #(
  parameter logic [1:0] MAX_EXP   = wide_neg_pkg::EXP_32,
  parameter int         RETRY_LIM = wide_neg_pkg::RETRY_MAX,
  parameter int         TMO_LIM   = wide_neg_pkg::TMO_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  wide_link_if.target     lk,
  input  wire logic       reneg,
  input  wire logic       sync_on,
  output logic [1:0]      data_exp_q,
  output logic            srev_q,
  output logic            cat_q,
  output logic            done_q
);
  import wide_neg_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_DATA, S_RX, S_TX, S_FREE} tstate_t;

  // ==========================================================
  // state
  // ==========================================================
  tstate_t         st_q, st_d;
  phase_t          ph_q, ph_d;
  msg_kind_t       kind_q, kind_d;
  logic [1:0]      idx_q, idx_d, resp_q, resp_d, dexp_d;
  logic [7:0]      db_q, db_d;
  logic [ID_W-1:0] id_q, id_d;
  logic [RT_W-1:0] rt_q, rt_d;
  logic [TMO_W-1:0] tmo_q, tmo_d;
  logic            req_q, req_d, orig_q, orig_d, chk_q, chk_d;
  logic            srev_d, cat_d, done_d;
  logic [1:0]      w_q [NPEER];
  logic [1:0]      w_d [NPEER];
  logic [NPEER-1:0] need_q, need_d;
  logic            wr_en, nd_clr, nd_set;
  logic [1:0]      wr_val;
  logic            tk, d_wdtr, d_rej, d_perr, d_bdr, d_junk, d_mid, rt_end;

  assign tk     = req_q && lk.ack;
  assign rt_end = (rt_q >= RT_W'(RETRY_LIM - 1));

  msg_decode u_dec (
    .clk     (clk),
    .srst    (srst),
    .clr     (st_q != S_RX),
    .take    (tk && st_q == S_RX),
    .byte_in (lk.ini_db),
    .wdtr_ok (d_wdtr),
    .rej     (d_rej),
    .perr    (d_perr),
    .bdr     (d_bdr),
    .junk    (d_junk),
    .mid     (d_mid)
  );

  task automatic go(input tstate_t s, input phase_t p);
    st_d = s;
    ph_d = p;
  endtask : go

  task automatic tx(input msg_kind_t k);
    go(S_TX, PH_MSG_IN);
    kind_d = k;
    idx_d  = IDX_EXT;
  endtask : tx

  task automatic settle(input logic [1:0] v);
    wr_en  = 1'b1;
    wr_val = v;
    nd_clr = 1'b1;
    done_d = 1'b1;
  endtask : settle

  // ==========================================================
  // negotiation sequencer
  // ==========================================================
  always_comb begin
    st_d = st_q; ph_d = ph_q; kind_d = kind_q; idx_d = idx_q; resp_d = resp_q;
    orig_d = orig_q; chk_d = chk_q; rt_d = rt_q; id_d = id_q;
    wr_en = 1'b0; wr_val = EXP_8; nd_clr = 1'b0; nd_set = 1'b0;
    srev_d = 1'b0; cat_d = 1'b0; done_d = 1'b0;
    tmo_d = tk ? '0 : tmo_q + TMO_W'(1);
    case (st_q)
      S_IDLE: begin
        ph_d = PH_FREE;
        if (lk.sel) begin
          id_d   = lk.ini_id;
          rt_d   = '0;
          chk_d  = 1'b0;
          orig_d = 1'b0;
          if (lk.atn) go(S_RX, PH_MSG_OUT);
          else if (need_q[lk.ini_id]) begin
            tx(MK_WDTR);
            orig_d = 1'b1;
            resp_d = MAX_EXP;
          end else go(S_DATA, PH_DATA);
        end
      end
      S_DATA: begin
        if (!lk.sel) go(S_IDLE, PH_FREE);
        else if (lk.atn) begin
          go(S_RX, PH_MSG_OUT);
          orig_d = 1'b0;
          chk_d  = 1'b0;
        end
      end
      S_TX: if (tk) begin
        if (!msg_last(kind_q, idx_q)) idx_d = idx_q + 2'h1;
        else if (kind_q == MK_REJ) begin
          settle(EXP_8);
          go(S_DATA, PH_DATA);
        end else if (orig_q) begin
          if (lk.atn) go(S_RX, PH_MSG_OUT);
          else begin
            settle(EXP_8);
            go(S_DATA, PH_DATA);
          end
        end else begin
          settle(resp_q);
          if (lk.atn) begin
            go(S_RX, PH_MSG_OUT);
            chk_d = 1'b1;
          end else go(S_DATA, PH_DATA);
        end
      end
      S_RX: begin
        if (d_wdtr && orig_q) begin
          if (lk.ini_db > {6'h00, resp_q}) tx(MK_REJ);
          else begin
            settle(lk.ini_db[1:0]);
            srev_d = sync_on;
            go(S_DATA, PH_DATA);
          end
        end else if (d_wdtr) begin
          resp_d = resp_exp(lk.ini_db, MAX_EXP);
          srev_d = sync_on;
          rt_d   = '0;
          tx(MK_WDTR);
        end else if (d_rej) begin
          settle(EXP_8);
          go(S_DATA, PH_DATA);
        end else if (d_perr && chk_q) begin
          wr_en = 1'b1;
          if (rt_end) begin
            settle(EXP_8);
            go(S_FREE, PH_FREE);
          end else begin
            rt_d = rt_q + RT_W'(1);
            tx(MK_WDTR);
          end
        end else if (d_bdr) begin
          wr_en  = 1'b1;
          nd_set = 1'b1;
          go(S_FREE, PH_FREE);
        end else if (d_junk && orig_q) begin
          if (rt_end) begin
            settle(EXP_8);
            cat_d = 1'b1;
            go(S_FREE, PH_FREE);
          end else rt_d = rt_q + RT_W'(1);
        end else if (!lk.atn && !d_mid && !tk) begin
          if (orig_q) settle(EXP_8);
          go(S_DATA, PH_DATA);
        end
      end
      S_FREE: if (!lk.sel) go(S_IDLE, PH_FREE);
      default: go(S_IDLE, PH_FREE);
    endcase
    // a stalled exchange must not hang the bus
    if ((st_q == S_TX || st_q == S_RX) && tmo_q == TMO_W'(TMO_LIM - 1)) begin
      settle(EXP_8);
      go(S_FREE, PH_FREE);
    end
    if (st_d != S_TX && st_d != S_RX) tmo_d = '0;
    req_d  = (st_d == S_TX || st_d == S_RX) && !tk;
    db_d   = msg_byte(kind_d, idx_d, resp_d);
    dexp_d = (ph_d == PH_DATA) ? (wr_en ? wr_val : w_q[id_d]) : EXP_8;
  end

  // ==========================================================
  // per-peer width table
  // ==========================================================
  for (genvar g = 0; g < NPEER; g++) begin : g_peer
    logic hit;
    assign hit = (id_q == ID_W'(g));
    always_comb begin
      w_d[g] = (wr_en && hit) ? wr_val : w_q[g];
      // set beats clear so a reset request is never lost
      need_d[g] = reneg || (nd_set && hit) || (need_q[g] && !(nd_clr && hit));
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        w_q[g]    <= EXP_8;
        need_q[g] <= 1'b1;
      end else begin
        w_q[g]    <= w_d[g];
        need_q[g] <= need_d[g];
      end
    end
  end

  assign lk.phase  = ph_q;
  assign lk.req    = req_q;
  assign lk.tgt_db = db_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= S_IDLE; ph_q <= PH_FREE; kind_q <= MK_WDTR; idx_q <= IDX_EXT;
      resp_q <= EXP_8; orig_q <= 1'b0; chk_q <= 1'b0; rt_q <= '0; id_q <= '0;
      tmo_q <= '0; req_q <= 1'b0; db_q <= 8'h00; data_exp_q <= EXP_8;
      srev_q <= 1'b0; cat_q <= 1'b0; done_q <= 1'b0;
    end else begin
      st_q <= st_d; ph_q <= ph_d; kind_q <= kind_d; idx_q <= idx_d;
      resp_q <= resp_d; orig_q <= orig_d; chk_q <= chk_d; rt_q <= rt_d; id_q <= id_d;
      tmo_q <= tmo_d; req_q <= req_d; db_q <= db_d; data_exp_q <= dexp_d;
      srev_q <= srev_d; cat_q <= cat_d; done_q <= done_d;
    end
  end
endmodule : wide_target

// ==== wide_link_checker.sv ====
// Purpose: protocol assertions on the width negotiation link
// Assumes: one clock, srst synchronous active high
// Notes: sees interface signals only, instantiated beside the link
`timescale 1ns/1ns
module wide_link_checker (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire wide_neg_pkg::phase_t          phase,
  input wire logic                          req,
  input wire logic [7:0]                    tgt_db,
  input wire logic                          ack,
  input wire logic                          atn,
  input wire logic                          sel,
  input wire logic [7:0]                    ini_db,
  input wire logic [wide_neg_pkg::ID_W-1:0] ini_id
);
  import wide_neg_pkg::*;
  // ==========================================================
  // last byte seen in each direction
  logic [7:0] tgt_last_q;
  logic [7:0] tgt_last_d;
  logic [7:0] ini_last_q;
  logic [7:0] ini_last_d;
  logic       msg_ph;
  logic       tgt_take;
  logic       ini_take;
  assign msg_ph   = (phase == PH_MSG_OUT) || (phase == PH_MSG_IN);
  assign tgt_take = req && ack && (phase == PH_MSG_IN);
  assign ini_take = ack && (phase == PH_MSG_OUT);
  always_comb begin
    tgt_last_d = tgt_take ? tgt_db : tgt_last_q;
    ini_last_d = ini_take ? ini_db : ini_last_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      tgt_last_q <= 8'h00;
      ini_last_q <= 8'h00;
    end else begin
      tgt_last_q <= tgt_last_d;
      ini_last_q <= ini_last_d;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_follows_req: assert property ($rose(req) && msg_ph |=> ack)
    else $error("ack missing after req");
  a_req_drops: assert property (ack |=> !req)
    else $error("req held after ack");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ack |-> req && msg_ph)
    else $error("ack without req");
  a_tgt_code_order: assert property (tgt_take && tgt_db == MSG_WIDE |-> tgt_last_q == MSG_LEN)
    else $error("target code byte out of order");
  a_tgt_exp_range: assert property (tgt_take && tgt_last_q == MSG_WIDE |-> tgt_db <= 8'h02)
    else $error("target exponent reserved");
  a_ini_code_order: assert property (ini_take && ini_db == MSG_WIDE |-> ini_last_q == MSG_LEN)
    else $error("initiator code byte out of order");
  a_ini_exp_range: assert property (ini_take && ini_last_q == MSG_WIDE |-> ini_db <= 8'h02)
    else $error("initiator exponent reserved");
  // message out is only entered on attention
  a_msgout_atn: assert property (phase == PH_MSG_OUT && $past(phase) != PH_MSG_OUT |-> atn)
    else $error("message out without atn");
  a_reset_idle: assert property ($fell(srst) |-> phase == PH_FREE && !req && !ack && !atn)
    else $error("link not idle after reset");
  c_data: cover property (phase == PH_DATA);
  c_perr: cover property (ini_take && ini_db == MSG_PERR);
  c_tgt_orig: cover property ($rose(atn) && phase == PH_MSG_IN);
endmodule : wide_link_checker

// ==== tb.sv ====
// Purpose: self-checking bench joining both negotiation ends
// Assumes: initiator limited to 16 bits, target to 32 bits
// Notes: pulses are counted at rising edges, inputs move on falling
`timescale 1ns/1ns
module tb;
  import wide_neg_pkg::*;
  logic       clk         = 1'b0;
  logic       srst        = 1'b1;
  logic       connect     = 1'b0;
  logic       i_reneg     = 1'b0;
  logic       inject_perr = 1'b0;
  logic       t_reneg     = 1'b0;
  logic       sync_on     = 1'b0;
  logic [1:0] ini_width;
  logic [1:0] tgt_exp;
  logic       t_srev;
  logic       i_srev;
  logic       fail_p;
  logic       cat_p;
  logic       done_p;
  int         error_cnt   = 0;
  int         checked     = 0;
  int         done_n      = 0;
  int         srev_n      = 0;
  int         fail_n      = 0;
  int         cat_n       = 0;
  int         isrev_n     = 0;

  wide_link_if lk ();
  wide_initiator #(.MAX_EXP(EXP_16)) u_wide_initiator (.clk(clk), .srst(srst), .lk(lk),
    .connect(connect), .my_id(4'h5), .reneg(i_reneg), .inject_perr(inject_perr),
    .width_q(ini_width), .srev_q(i_srev), .fail_q(fail_p));
  // short timeout keeps stalled cases brief
  wide_target #(.MAX_EXP(EXP_32), .RETRY_LIM(RETRY_MAX), .TMO_LIM(16)) u_wide_target (
    .clk(clk), .srst(srst), .lk(lk), .reneg(t_reneg), .sync_on(sync_on),
    .data_exp_q(tgt_exp), .srev_q(t_srev), .cat_q(cat_p), .done_q(done_p));
  wide_link_checker u_wide_link_checker (.clk(clk), .srst(srst), .phase(lk.phase),
    .req(lk.req), .tgt_db(lk.tgt_db), .ack(lk.ack), .atn(lk.atn), .sel(lk.sel),
    .ini_db(lk.ini_db), .ini_id(lk.ini_id));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (done_p === 1'b1) done_n++;
    if (t_srev === 1'b1) srev_n++;
    if (fail_p === 1'b1) fail_n++;
    if (cat_p === 1'b1) cat_n++;
    if (i_srev === 1'b1) isrev_n++;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic wait_phase(input phase_t p);
    int n;
    n = 0;
    while (lk.phase !== p && n < 400) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, n < 400}, 8'h01, "phase wait");
  endtask : wait_phase
  task automatic session(input bit neg, input logic [1:0] exp_w);
    int n0;
    int n;
    n0 = done_n;
    n = 0;
    connect = 1'b1;
    while (neg && done_n == n0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, n < 400}, 8'h01, "exchange settles");
    wait_phase(PH_DATA);
    @(negedge clk);
    check({6'h00, tgt_exp}, {6'h00, exp_w}, "target data width");
    check({6'h00, ini_width}, {6'h00, exp_w}, "initiator width");
    connect = 1'b0;
    wait_phase(PH_FREE);
    @(negedge clk);
    check({6'h00, tgt_exp}, {6'h00, EXP_8}, "width outside data");
  endtask : session
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check({6'h00, ini_width}, {6'h00, EXP_8}, "reset width");
    check({6'h00, tgt_exp}, {6'h00, EXP_8}, "reset data width");
    check({5'h00, lk.phase}, {5'h00, PH_FREE}, "reset phase");
    $display("test reset done");
  endtask : t_reset
  task automatic t_ini_orig();
    int s0;
    s0 = srev_n;
    sync_on = 1'b1;
    session(1'b1, EXP_16);
    check({7'h00, srev_n > s0}, 8'h01, "sync revert");
    sync_on = 1'b0;
    $display("test initiator origin done");
  endtask : t_ini_orig
  task automatic t_keep();
    int n0;
    n0 = done_n;
    session(1'b0, EXP_16);
    check({7'h00, done_n == n0}, 8'h01, "no renegotiation");
    $display("test keep done");
  endtask : t_keep
  task automatic t_tgt_orig();
    int s0;
    s0 = isrev_n;
    t_reneg = 1'b1;
    @(negedge clk);
    t_reneg = 1'b0;
    session(1'b1, EXP_16);
    check({7'h00, isrev_n > s0}, 8'h01, "initiator commit");
    $display("test target origin done");
  endtask : t_tgt_orig
  task automatic t_perr();
    int f0;
    f0 = fail_n;
    i_reneg = 1'b1;
    inject_perr = 1'b1;
    @(negedge clk);
    i_reneg = 1'b0;
    session(1'b1, EXP_16);
    inject_perr = 1'b0;
    check({7'h00, fail_n == f0}, 8'h01, "no abort");
    check({7'h00, cat_n == 0}, 8'h01, "no catastrophe");
    $display("test parity retry done");
  endtask : t_perr
  task automatic t_mid_reset();
    connect = 1'b1;
    wait_phase(PH_DATA);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    connect = 1'b0;
    @(negedge clk);
    check({6'h00, ini_width}, {6'h00, EXP_8}, "width after reset");
    check({5'h00, lk.phase}, {5'h00, PH_FREE}, "phase after reset");
    session(1'b1, EXP_16);
    $display("test mid reset done");
  endtask : t_mid_reset
  // ==========================================================
  // run control
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset();
    t_ini_orig();
    t_keep();
    t_tgt_orig();
    t_perr();
    t_mid_reset();
    tally_and_finish();
  end
  // whole run is a few hundred cycles; this limit is 20000 cycles, far above that
  initial begin
    #80000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
